// file: logic/tcc_pkg.sv
/*
  package for the timer capture and compare block: register offsets,
  field positions, mode codes and the apb carrier struct.
  assumes a 32-bit apb master and two shared 16-bit timer counts outside.
*/
// Summary of operation
// [R1] capture stores full 16-bit selected timer count
// [R2] mode picks edge, every 4th or 16th rise
// [R3] modes 000 and 110 disable capture
// [R4] mode 111: rising edge wake interrupt only
// [R5] timer select 1 second, 0 third timer
// [R6] interrupt every 1,2,3,4 captures
// [R7] every-edge mode ignores captures-per-interrupt
// [R8] four-deep capture fifo read in order
// [R9] buffer-not-empty flag while unread values exist
// [R10] overflow flag set on capture overflow
// [R11] capture stop-in-idle halts channel in idle; the code still raises the mode 111 wake in idle
// [R12] compare select 1 third, 0 second timer
// [R13] modes 001/010 init low/high, match flips
// [R14] toggle keeps level, interrupts both edges
// [R15] modes 100/101 single/continuous pulse, start low
// [R16] pwm modes, init by primary value, fault
// [R17] compare interrupt edge follows mode
// [R18] fault falling edge interrupts in mode 111
// [R19] fault status set by hardware only
// [R20] mode 000 leaves pin to gpio
// [R21] compare stop-in-idle halts channel in idle
// [R22] software stops timer before compare writes
// [R23] full fifo: overflow set, new value dropped
`default_nettype none
package tcc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CAP_CTRL  = 8'h00; // capture channel control
  localparam logic [7:0] OFS_CAP_BUF   = 8'h04; // capture fifo pop
  localparam logic [7:0] OFS_CMP_CTRL  = 8'h08; // compare channel control
  localparam logic [7:0] OFS_CMP_PRI   = 8'h0C; // primary compare value
  localparam logic [7:0] OFS_CMP_SEC   = 8'h10; // secondary compare value
  localparam logic [7:0] OFS_CMP_CLR   = 8'h14; // unmapped hole, answers with an error
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_SIDL  = 13; // stop in idle, both controls
  localparam int BIT_CTMR  = 7;  // capture timer select
  localparam int BIT_CPI   = 5;  // captures per interrupt lsb
  localparam int BIT_COV   = 4;  // capture overflow
  localparam int BIT_BNE   = 3;  // buffer not empty
  localparam int BIT_FLT   = 4;  // compare fault status
  localparam int BIT_OTSEL = 3;  // compare timer select
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_VAL  = 16'h0000;
  localparam int FIFO_DEPTH = 4;
  // ------------------------------------------------------------
  // mode codes
  // ------------------------------------------------------------
  localparam logic [2:0] M_OFF = 3'h0, M_1 = 3'h1, M_2 = 3'h2, M_3 = 3'h3;
  localparam logic [2:0] M_4 = 3'h4, M_5 = 3'h5, M_6 = 3'h6, M_7 = 3'h7;
  // apb request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_type;
endpackage : tcc_pkg
`default_nettype wire

// file: logic/tcc_top.sv
/*
  timer capture and compare unit: one capture channel with a four word
  fifo and one compare channel, registers over apb.
  assumes the timer counts arrive on the same clock; pins are async.
*/
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tcc_top #(
  parameter int CNT_W = 16 // timer width
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_sys_rst,
  // apb slave
  input  wire tcc_pkg::tcc_apb_req_type i_apb,
  output logic [31:0]           o_prdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  // time bases and power state
  input  wire logic [CNT_W-1:0] i_second_timer_count,
  input  wire logic [CNT_W-1:0] i_third_timer_count,
  input  wire logic             i_cpu_idle,
  input  wire logic             i_cpu_sleep,
  // pins
  input  wire logic             i_capture_input_pin,
  input  wire logic             i_compare_fault_input,
  output logic                  o_compare_output_pin,
  output logic                  o_compare_output_oe,
  // events
  output logic                  o_capture_irq,
  output logic                  o_capture_wake,
  output logic                  o_compare_irq
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] cap_sync_reg;   // capture pin two-stage
  logic [1:0] flt_sync_reg;   // fault pin two-stage
  logic       cap_d_reg;      // previous synced capture level
  logic       flt_d_reg;      // previous synced fault level
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap_sync_reg <= 2'h0;
      flt_sync_reg <= 2'h3;
      cap_d_reg    <= 1'b0;
      flt_d_reg    <= 1'b1;
    end else begin
      cap_sync_reg <= {cap_sync_reg[0], i_capture_input_pin};
      flt_sync_reg <= {flt_sync_reg[0], i_compare_fault_input};
      cap_d_reg    <= cap_sync_reg[1];
      flt_d_reg    <= flt_sync_reg[1];
    end
  end
  wire cap_rise = cap_sync_reg[1] & ~cap_d_reg;
  wire cap_fall = ~cap_sync_reg[1] & cap_d_reg;
  wire flt_fall = ~flt_sync_reg[1] & flt_d_reg;
  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  wire       acc   = i_apb.psel & i_apb.penable;
  wire       wr    = acc & i_apb.pwrite;
  wire       rd    = acc & ~i_apb.pwrite;
  wire [7:0] addr  = i_apb.paddr;
  wire       a_cc  = addr == tcc_pkg::OFS_CAP_CTRL;
  wire       a_cb  = addr == tcc_pkg::OFS_CAP_BUF;
  wire       a_oc  = addr == tcc_pkg::OFS_CMP_CTRL;
  wire       a_pr  = addr == tcc_pkg::OFS_CMP_PRI;
  wire       a_se  = addr == tcc_pkg::OFS_CMP_SEC;
  wire       a_ok  = a_cc | a_cb | a_oc | a_pr | a_se;
  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic        cap_sidl_reg;          // capture stop in idle
  logic        cap_tsel_reg;          // capture timer select
  logic [1:0]  cap_cpi_reg;           // captures per interrupt
  logic [2:0]  cap_mode_reg;          // capture mode field
  logic        cmp_sidl_reg;          // compare stop in idle
  logic        cmp_tsel_reg;          // compare timer select
  logic [2:0]  cmp_mode_reg;          // compare mode field
  logic [15:0] pri_reg;               // primary compare value
  logic [15:0] sec_reg;               // secondary compare value
  wire         cc_wr = wr & a_cc;
  wire         oc_wr = wr & a_oc;
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cap_sidl_reg <= 1'b0;
      cap_tsel_reg <= 1'b0;
      cap_cpi_reg  <= 2'h0;
      cap_mode_reg <= tcc_pkg::M_OFF;
      cmp_sidl_reg <= 1'b0;
      cmp_tsel_reg <= 1'b0;
      cmp_mode_reg <= tcc_pkg::M_OFF;
      pri_reg      <= tcc_pkg::RST_VAL;
      sec_reg      <= tcc_pkg::RST_VAL;
    end else begin
      if (cc_wr) begin
        cap_sidl_reg <= i_apb.pwdata[tcc_pkg::BIT_SIDL];
        cap_tsel_reg <= i_apb.pwdata[tcc_pkg::BIT_CTMR];
        cap_cpi_reg  <= i_apb.pwdata[tcc_pkg::BIT_CPI+:2];
        cap_mode_reg <= i_apb.pwdata[2:0];
      end
      // timer expected stopped by software here [R22]
      if (oc_wr) begin
        cmp_sidl_reg <= i_apb.pwdata[tcc_pkg::BIT_SIDL];
        cmp_tsel_reg <= i_apb.pwdata[tcc_pkg::BIT_OTSEL];
        cmp_mode_reg <= i_apb.pwdata[2:0];
      end
      if (wr & a_pr) pri_reg <= i_apb.pwdata[15:0];
      if (wr & a_se) sec_reg <= i_apb.pwdata[15:0];
    end
  end
  // ------------------------------------------------------------
  // capture event qualification
  // ------------------------------------------------------------
  wire        cap_halt = cap_sidl_reg & i_cpu_idle;               // [R11]
  wire        cap_run  = ~cap_halt & (cap_mode_reg != tcc_pkg::M_OFF)
                         & (cap_mode_reg != tcc_pkg::M_6)
                         & (cap_mode_reg != tcc_pkg::M_7);        // [R3] [R4]
  logic [3:0] pre_reg;                                            // rising edge prescaler
  wire        pre_hit  = (cap_mode_reg == tcc_pkg::M_4) ? (pre_reg[1:0] == 2'h3)
                       : (pre_reg == 4'hF);
  logic       cap_ev;
  always_comb begin
    case (cap_mode_reg)                                           // [R2]
      tcc_pkg::M_1: cap_ev = cap_rise | cap_fall;
      tcc_pkg::M_2: cap_ev = cap_fall;
      tcc_pkg::M_3: cap_ev = cap_rise;
      tcc_pkg::M_4, tcc_pkg::M_5: cap_ev = cap_rise & pre_hit;
      default: cap_ev = 1'b0;
    endcase
  end
  wire        cap_take = cap_run & cap_ev;
  wire [15:0] cap_val  = cap_tsel_reg ? i_second_timer_count : i_third_timer_count; // [R5]
  // ------------------------------------------------------------
  // capture fifo
  // ------------------------------------------------------------
  logic [15:0] fifo_mem [tcc_pkg::FIFO_DEPTH];  // stored captures
  logic [1:0]  wp_reg;                          // write pointer
  logic [1:0]  rp_reg;                          // read pointer
  logic [2:0]  cnt_reg;                         // fill count
  logic        ov_reg;                          // overflow flag
  logic [1:0]  icnt_reg;                        // captures since interrupt
  wire         full  = cnt_reg == 3'h4;
  wire         empty = cnt_reg == 3'h0;
  wire         pop   = rd & a_cb & ~empty;
  wire         push  = cap_take & ~full;                          // [R23]
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_reg <= 2'h0;
      rp_reg <= 2'h0;
      cnt_reg <= 3'h0;
      ov_reg <= 1'b0;
      pre_reg <= 4'h0;
      icnt_reg <= 2'h0;
    end else begin
      if (cap_run & cap_rise) pre_reg <= pre_reg + 4'h1;
      else if (cc_wr) pre_reg <= 4'h0;
      if (push) wp_reg <= wp_reg + 2'h1;                          // [R1] [R8]
      if (pop) rp_reg <= rp_reg + 2'h1;                           // [R8]
      cnt_reg <= cnt_reg + {2'h0, push} - {2'h0, pop};
      // overflow set wins; cleared by hardware when fifo drains
      if (cap_take & full) ov_reg <= 1'b1;                        // [R10] [R23]
      else if (empty | (cc_wr & i_apb.pwdata[2:0] == tcc_pkg::M_OFF)) ov_reg <= 1'b0;
      if (cc_wr) icnt_reg <= 2'h0;
      else if (push) icnt_reg <= (icnt_reg == cap_cpi_reg) ? 2'h0 : icnt_reg + 2'h1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (push) fifo_mem[wp_reg] <= cap_val;
  end
  // ------------------------------------------------------------
  // capture interrupt and wake
  // ------------------------------------------------------------
  wire cap_irq_next = push & ((cap_mode_reg == tcc_pkg::M_1)      // [R7]
                      | (icnt_reg == cap_cpi_reg));               // [R6]
  wire wake_next    = (cap_mode_reg == tcc_pkg::M_7) & cap_rise
                      & (i_cpu_sleep | i_cpu_idle);               // [R4]
  // ------------------------------------------------------------
  // compare channel
  // ------------------------------------------------------------
  wire        cmp_halt = cmp_sidl_reg & i_cpu_idle;               // [R21]
  wire [15:0] tb       = cmp_tsel_reg ? i_third_timer_count : i_second_timer_count; // [R12]
  wire        m_pri    = tb == pri_reg;
  wire        m_sec    = tb == sec_reg;
  logic       pin_reg;                   // compare pin level
  logic       flt_reg;                   // fault status
  logic       done_reg;                  // one-shot finished
  logic       cirq_reg;                  // compare interrupt pulse
  logic       pin_next;
  logic       done_next;
  wire        enter = oc_wr;             // mode entry initialises pin
  wire [2:0]  nm    = i_apb.pwdata[2:0];
  always_comb begin
    pin_next  = pin_reg;
    done_next = done_reg;
    if (enter) begin
      done_next = 1'b0;
      case (nm)
        tcc_pkg::M_1, tcc_pkg::M_4, tcc_pkg::M_5: pin_next = 1'b0; // [R13] [R15]
        tcc_pkg::M_2: pin_next = 1'b1;                             // [R13]
        tcc_pkg::M_6, tcc_pkg::M_7: pin_next = pri_reg != 16'h0000; // [R16]
        default: pin_next = pin_reg;                               // [R14]
      endcase
    end else if (!cmp_halt) begin
      case (cmp_mode_reg)
        tcc_pkg::M_1: if (m_pri & ~done_reg) begin pin_next = 1'b1; done_next = 1'b1; end
        tcc_pkg::M_2: if (m_pri & ~done_reg) begin pin_next = 1'b0; done_next = 1'b1; end
        tcc_pkg::M_3: if (m_pri) pin_next = ~pin_reg;              // [R14]
        tcc_pkg::M_4, tcc_pkg::M_5: begin                          // [R15]
          if (m_pri & ~done_reg) pin_next = 1'b1;
          else if (m_sec & pin_reg) begin
            pin_next  = 1'b0;
            done_next = cmp_mode_reg == tcc_pkg::M_4;
          end
        end
        tcc_pkg::M_6, tcc_pkg::M_7: begin                          // [R16]
          if (cmp_mode_reg == tcc_pkg::M_7 & (flt_reg | flt_fall)) pin_next = 1'b0;
          else if (tb == 16'h0000) pin_next = pri_reg != 16'h0000;
          else if (m_pri) pin_next = 1'b0;
        end
        default: pin_next = pin_reg;
      endcase
    end
  end
  wire rise_o = pin_next & ~pin_reg;
  wire fall_o = ~pin_next & pin_reg;
  logic cirq_next;
  always_comb begin
    case (cmp_mode_reg)                                            // [R17]
      tcc_pkg::M_1: cirq_next = rise_o;
      tcc_pkg::M_2, tcc_pkg::M_4, tcc_pkg::M_5: cirq_next = fall_o;
      tcc_pkg::M_3: cirq_next = rise_o | fall_o;                   // [R14]
      tcc_pkg::M_7: cirq_next = flt_fall & ~cmp_halt;              // [R18]
      default: cirq_next = 1'b0;
    endcase
    if (enter) cirq_next = 1'b0;
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_reg  <= 1'b0;
      flt_reg  <= 1'b0;
      done_reg <= 1'b0;
      cirq_reg <= 1'b0;
    end else begin
      pin_reg  <= pin_next;
      done_reg <= done_next;
      cirq_reg <= cirq_next;
      // hardware sets on fault, clears only when leaving pwm-fault mode
      if (cmp_mode_reg == tcc_pkg::M_7 & flt_fall & ~cmp_halt) flt_reg <= 1'b1; // [R19]
      else if (cmp_mode_reg != tcc_pkg::M_7) flt_reg <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // read mux and registered outputs
  // ------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (a_cc) rdata = {18'h0, cap_sidl_reg, 5'h0, cap_tsel_reg, cap_cpi_reg,
                       ov_reg, ~empty, cap_mode_reg};              // [R9] [R10]
    if (a_cb) rdata = {16'h0, fifo_mem[rp_reg]};
    if (a_oc) rdata = {18'h0, cmp_sidl_reg, 8'h0, flt_reg, cmp_tsel_reg, cmp_mode_reg};
    if (a_pr) rdata = {16'h0, pri_reg};
    if (a_se) rdata = {16'h0, sec_reg};
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_capture_irq <= 1'b0;
      o_capture_wake <= 1'b0;
      o_compare_irq <= 1'b0;
      o_compare_output_pin <= 1'b0;
      o_compare_output_oe <= 1'b0;
    end else begin
      o_prdata <= rdata;
      o_pready <= i_apb.psel & ~i_apb.penable; // no wait states
      o_pslverr <= i_apb.psel & ~i_apb.penable & ~a_ok;
      o_capture_irq <= cap_irq_next;
      o_capture_wake <= wake_next;
      o_compare_irq <= cirq_reg;
      o_compare_output_pin <= pin_reg;
      o_compare_output_oe <= cmp_mode_reg != tcc_pkg::M_OFF;  // [R20]
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_OVF_DROP: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R23]
    cap_take & full |=> ov_reg & (cnt_reg == 3'h4 || $past(pop)))
    else $error("overflow not flagged");
  AST_BNE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R9]
    push & ~pop |=> cnt_reg != 3'h0)
    else $error("buffer empty after push");
  AST_OFF: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R3]
    (cap_mode_reg == tcc_pkg::M_6 || cap_mode_reg == tcc_pkg::M_OFF) |-> ~push)
    else $error("disabled channel captured");
  AST_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R11]
    cap_halt |-> ~push)
    else $error("capture during idle halt");
  AST_OE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R20]
    cmp_mode_reg == tcc_pkg::M_OFF |=> ~o_compare_output_oe)
    else $error("pin driven while disabled");
  AST_PWM_IRQ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R17]
    cmp_mode_reg == tcc_pkg::M_6 |=> ~cirq_reg)
    else $error("pwm mode interrupted");
  AST_FLT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R19]
    cmp_mode_reg == tcc_pkg::M_7 & flt_fall & ~cmp_halt |=> flt_reg ##1 ~pin_reg)
    else $error("fault not latched");
  AST_SET_HI: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst) // [R13]
    oc_wr & nm == tcc_pkg::M_2 |=> pin_reg ##2 o_compare_output_pin)
    else $error("mode 010 not initialised high");
endmodule : tcc_top
`default_nettype wire

// file: testbench/tcc_pin_model.sv
/*
  pin-side model: the two shared timer counts, the capture pin source
  and the compare fault source, all driven on the rising clock edge.
  assumes the bench calls its tasks by hierarchical name, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  // clock
  input  wire logic   i_clk_sys,
  // to the block
  output logic [15:0] o_second_timer_count,
  output logic [15:0] o_third_timer_count,
  output logic        o_capture_input_pin,
  output logic        o_compare_fault_input
);
  // idle levels at time zero: pin low, fault released high
  initial begin
    o_second_timer_count  = 16'h0000;
    o_third_timer_count   = 16'h0000;
    o_capture_input_pin   = 1'b0;
    o_compare_fault_input = 1'b1;
  end
  // timers held still, as software stops them before setup
  task automatic set_timers(input logic [15:0] a, input logic [15:0] b);
    @(posedge i_clk_sys);
    o_second_timer_count <= a;
    o_third_timer_count  <= b;
  endtask : set_timers
  // one full pin pulse, long enough for the two-flop synchroniser
  task automatic pulse();
    @(posedge i_clk_sys);
    o_capture_input_pin <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    o_capture_input_pin <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
  endtask : pulse
  // one timer sits on v for a single cycle, then steps past it
  task automatic hit(input logic th, input logic [15:0] v);
    @(posedge i_clk_sys);
    if (th) o_third_timer_count <= v;
    else o_second_timer_count <= v;
    @(posedge i_clk_sys);
    if (th) o_third_timer_count <= v + 16'h0001;
    else o_second_timer_count <= v + 16'h0001;
  endtask : hit
  // active-low fault: falling edge, then released high again
  task automatic fault_fall();
    @(posedge i_clk_sys);
    o_compare_fault_input <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    o_compare_fault_input <= 1'b1;
  endtask : fault_fall
endmodule : tcc_pin_model
`default_nettype wire

// file: testbench/timer_capture_and_compare_channels_test.sv
/*
  bench: capture modes as table rows, then overflow, idle, wake,
  compare modes and an unmapped access by hand.
  assumes tcc_top answers apb with pready and the pin model above.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_capture_and_compare_channels_test;
  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  typedef struct {int mode; int sel; int cpi; int npul; int ncap; int nirq;} tcc_row_type;
  logic clk, rst, idle, sleep, pin, flt, pready, perr, err, oc_pin, oc_oe, cirq, wake, oirq;
  logic [15:0] t2, t3;
  logic [31:0] prdata, rv;
  tcc_pkg::tcc_apb_req_type req;
  int n_mismatch, checks_done, n_cirq, n_wake, n_oirq, c0, k;
  tcc_row_type t;
  // capture modes 000 to 110, with cpi settings, pulses and expected counts
  tcc_row_type rows [9] = '{'{1,1,3,2,4,4}, '{2,0,0,2,2,2}, '{3,1,1,2,2,1}, '{3,0,2,3,3,1},
    '{3,1,3,4,4,1}, '{4,0,0,4,1,1}, '{5,1,0,16,1,1}, '{0,1,0,2,0,0}, '{6,1,0,2,0,0}};
  // ----------------------------------------------------------
  // clock, instances, event counters
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tcc_top i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_apb(req), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(perr), .i_second_timer_count(t2), .i_third_timer_count(t3), .i_cpu_idle(idle),
    .i_cpu_sleep(sleep), .i_capture_input_pin(pin), .i_compare_fault_input(flt),
    .o_compare_output_pin(oc_pin), .o_compare_output_oe(oc_oe), .o_capture_irq(cirq),
    .o_capture_wake(wake), .o_compare_irq(oirq));
  tcc_pin_model i_src (.i_clk_sys(clk), .o_second_timer_count(t2), .o_third_timer_count(t3),
    .o_capture_input_pin(pin), .o_compare_fault_input(flt));
  always @(posedge clk) begin
    n_cirq += (cirq === 1'b1);
    n_wake += (wake === 1'b1);
    n_oirq += (oirq === 1'b1);
  end
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rv = prdata;
    err = perr;
    req <= '0;
    if (n >= 20) begin
      n_mismatch++;
      test_done();
    end
  endtask : apb
  function automatic logic [31:0] ctl(input int s, input int tm, input int c, input int m);
    return (32'(s) << 13) | (32'(tm) << tcc_pkg::BIT_CTMR) | (32'(c) << tcc_pkg::BIT_CPI) | 32'(m);
  endfunction : ctl
  function automatic logic [31:0] oct(input int s, input int tm, input int m);
    return (32'(s) << 13) | (32'(tm) << tcc_pkg::BIT_OTSEL) | 32'(m);
  endfunction : oct
  // one compare match on a timer, then pin level after the latency
  task automatic hchk(input logic th, input logic [15:0] v, input logic ep);
    i_src.hit(th, v);
    repeat (4) @(posedge clk);
    chk("oc_pin", {31'h0, ep}, {31'h0, oc_pin});
  endtask : hchk
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    rst = 1'b1;
    idle = 1'b0;
    sleep = 1'b0;
    req = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
    chk("cap_ctrl_rst", {16'h0, tcc_pkg::RST_CTRL}, rv);
    for (int r = 0; r < 9; r++) begin
      t = rows[r];
      apb(1, tcc_pkg::OFS_CAP_CTRL, ctl(0, t.sel, t.cpi, t.mode));
      c0 = n_cirq;
      for (int p = 0; p < t.npul; p++) begin
        i_src.set_timers(16'(r * 256 + p + 16), ~16'(r * 256 + p + 16));
        i_src.pulse();
      end
      chk("cap_irq", t.nirq, n_cirq - c0);
      apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
      chk("cap_bne", t.ncap != 0, rv[3]);
      for (int j = 0; j < t.ncap; j++) begin
        k = t.mode == 1 ? j / 2 : t.mode == 4 ? 3 : t.mode == 5 ? 15 : j;
        apb(0, tcc_pkg::OFS_CAP_BUF, 0);
        chk("cap_val", {16'h0, t.sel ? 16'(r * 256 + k + 16) : ~16'(r * 256 + k + 16)}, rv);
      end
    end
    // five captures into a four-deep buffer
    apb(1, tcc_pkg::OFS_CAP_CTRL, ctl(0, 1, 0, 3));
    for (int p = 0; p < 5; p++) begin
      i_src.set_timers(16'h7000 + 16'(p), 16'h0000);
      i_src.pulse();
    end
    apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
    chk("cap_ovf", 1, rv[4]);
    for (int j = 0; j < 4; j++) begin
      apb(0, tcc_pkg::OFS_CAP_BUF, 0);
      chk("cap_keep", {16'h0, 16'h7000 + 16'(j)}, rv);
    end
    apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
    chk("cap_empty", 0, {rv[4], rv[3]});
    // idle with and without stop-in-idle
    idle <= 1'b1;
    apb(1, tcc_pkg::OFS_CAP_CTRL, ctl(1, 1, 0, 3));
    i_src.pulse();
    apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
    chk("cap_idle_stop", 0, rv[3]);
    apb(1, tcc_pkg::OFS_CAP_CTRL, ctl(0, 1, 0, 3));
    i_src.pulse();
    apb(0, tcc_pkg::OFS_CAP_BUF, 0);
    chk("cap_idle_run", {16'h0, 16'h7004}, rv);
    // wake-only mode while asleep
    idle <= 1'b0;
    sleep <= 1'b1;
    apb(1, tcc_pkg::OFS_CAP_CTRL, ctl(0, 1, 3, 7));
    c0 = n_wake;
    i_src.pulse();
    chk("cap_wake", 1, n_wake - c0);
    apb(0, tcc_pkg::OFS_CAP_CTRL, 0);
    chk("cap_wake_nobuf", 0, rv[3]);
    sleep <= 1'b0;
    // compare: one-shot modes and timer select
    i_src.set_timers(16'h0001, 16'h0001);
    apb(1, tcc_pkg::OFS_CMP_PRI, 32'h0000_0040);
    apb(1, tcc_pkg::OFS_CMP_SEC, 32'h0000_0080);
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 1));
    c0 = n_oirq;
    hchk(1, 16'h0040, 0);
    chk("oc_oe", 1, oc_oe);
    hchk(0, 16'h0040, 1);
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 0));
    // enable output is two flops behind the mode write
    repeat (2) @(posedge clk);
    chk("oc_oe_off", 0, oc_oe);
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 1, 2));
    hchk(0, 16'h0040, 1);
    hchk(1, 16'h0040, 0);
    chk("oc_irq_oneshot", 2, n_oirq - c0);
    // toggle keeps the level, then flips on each match
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 3));
    c0 = n_oirq;
    hchk(0, 16'h0040, 1);
    hchk(0, 16'h0040, 0);
    chk("oc_irq_toggle", 2, n_oirq - c0);
    // single and repeating pulse between primary and secondary
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 4));
    c0 = n_oirq;
    hchk(0, 16'h0040, 1);
    hchk(0, 16'h0080, 0);
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 5));
    hchk(0, 16'h0040, 1);
    hchk(0, 16'h0080, 0);
    hchk(0, 16'h0040, 1);
    chk("oc_irq_pulse", 2, n_oirq - c0);
    // pwm without and with fault input
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 6));
    c0 = n_oirq;
    repeat (4) @(posedge clk);
    chk("oc_pwm_init", 1, oc_pin);
    hchk(0, 16'h0040, 0);
    hchk(0, 16'h0000, 1);
    chk("oc_irq_pwm", 0, n_oirq - c0);
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 7));
    i_src.fault_fall();
    repeat (2) @(posedge clk);
    chk("oc_irq_fault", 1, n_oirq - c0);
    chk("oc_fault_pin", 0, oc_pin);
    apb(0, tcc_pkg::OFS_CMP_CTRL, 0);
    chk("oc_fault_flag", 1, rv[4]);
    // a software rewrite of mode 111 must not clear the fault flag
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(0, 0, 7));
    apb(0, tcc_pkg::OFS_CMP_CTRL, 0);
    chk("oc_fault_kept", 32'h0000_0017, rv);
    // compare halts in idle with stop-in-idle set
    idle <= 1'b1;
    apb(1, tcc_pkg::OFS_CMP_CTRL, oct(1, 0, 1));
    hchk(0, 16'h0040, 0);
    idle <= 1'b0;
    apb(0, tcc_pkg::OFS_CMP_CLR, 0);
    chk("unmapped_err", 1, err);
    chk("unmapped_rd", 0, rv);
    test_done();
  end
endmodule : timer_capture_and_compare_channels_test
`default_nettype wire
